// *** src/arp_decoder.sv ***
// Answer-to-reset tail and global parameter decoder with AXI4-Lite access
`timescale 1ns/10ps
`default_nettype none
`include "arp_params.svh"

module arp_decoder (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire arp_pkg::arp_axil_req_s axi_req_i,
  output arp_pkg::arp_axil_rsp_s axi_rsp_o,
  input wire logic atr_start_i,
  input wire logic warm_reset_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic pps_done_i,
  input wire logic [7:0] pps_fidi_i,
  output arp_pkg::arp_out_s out_o
);
  import arp_pkg::*;

  // ******************************************************
  // Factor decoding
  // ******************************************************
  function automatic logic [11:0] arp_f(input logic [3:0] c);
    case (c)
      4'h0, 4'h1: arp_f = 12'h174;
      4'h2: arp_f = 12'h22E;
      4'h3: arp_f = 12'h2E8;
      4'h4: arp_f = 12'h45C;
      4'h5: arp_f = 12'h5D0;
      4'h6: arp_f = 12'h744;
      4'h9: arp_f = 12'h200;
      4'hA: arp_f = 12'h300;
      4'hB: arp_f = 12'h400;
      4'hC: arp_f = 12'h600;
      4'hD: arp_f = 12'h800;
      default: arp_f = 12'h000;
    endcase
  endfunction

  function automatic logic [5:0] arp_d(input logic [3:0] c);
    case (c)
      4'h1: arp_d = 6'h01;
      4'h2: arp_d = 6'h02;
      4'h3: arp_d = 6'h04;
      4'h4: arp_d = 6'h08;
      4'h5: arp_d = 6'h10;
      4'h6: arp_d = 6'h20;
      4'h8: arp_d = 6'h0C;
      4'h9: arp_d = 6'h14;
      default: arp_d = 6'h00;
    endcase
  endfunction

  // State after the format byte or after interface bytes
  function automatic arp_state_e arp_after(input logic [3:0] k,
                                           input logic tck);
    if (k != 4'h0)
      arp_after = ST_HIST;
    else if (tck)
      arp_after = ST_TCK;
    else
      arp_after = ST_DONE;
  endfunction

  // ******************************************************
  // Parser
  // ******************************************************
  arp_parse_s p_q, p_d;
  arp_bus_s b_q, b_d;
  arp_out_s o_q, o_d;
  logic [7:0] rb;

  assign rb = rx_byte_i;

  always_comb
  begin
    p_d = p_q;
    if (warm_reset_i)
    begin
      p_d.st = ST_IDLE;
      p_d.ta2 = 1'b0;
      p_d.pps_ok = 1'b0;
    end
    else if (atr_start_i)
    begin
      p_d = '0;
      p_d.st = ST_FMT;
      p_d.fi = `ARP_CODE_DFLT;
      p_d.di = `ARP_CODE_DFLT;
      p_d.ui = `ARP_UI_A;
    end
    else if (rx_valid_i)
    begin
      case (p_q.st)
        ST_FMT:
        begin
          p_d.xsum = rb;
          p_d.k = rb[3:0];
          p_d.pend = rb[7:4];
          p_d.idx = `ARP_IDX_ONE;
          if (rb[7:4] == 4'h0)
            p_d.st = arp_after(rb[3:0], 1'b0);
          else
            p_d.st = ST_IF;
        end
        ST_IF:
        begin
          p_d.xsum = p_q.xsum ^ rb;
          if (p_q.pend[0])
          begin
            p_d.pend[0] = 1'b0;
            if (p_q.idx == `ARP_IDX_ONE)
            begin
              p_d.ta1 = 1'b1;
              p_d.fi = rb[7:4];
              p_d.di = rb[3:0];
              if (arp_f(rb[7:4]) == 12'h000)
                p_d.err[`ARP_ERR_FI] = 1'b1;
              if (arp_d(rb[3:0]) == 6'h00)
                p_d.err[`ARP_ERR_DI] = 1'b1;
            end
            else if (p_q.idx == `ARP_IDX_TWO)
            begin
              p_d.ta2 = 1'b1;
              p_d.ta2v = rb;
            end
            else if (p_q.tprev == `ARP_T15 && !p_q.xu_done)
            begin
              p_d.xu_done = 1'b1;
              p_d.xi = rb[7:6];
              p_d.ui = rb[5:0];
              if (rb[5:0] == 6'h00 || rb[5:0] > `ARP_UI_AB)
                p_d.err[`ARP_ERR_UI] = 1'b1;
            end
          end
          else if (p_q.pend[1])
          begin
            p_d.pend[1] = 1'b0;
            if (p_q.idx == `ARP_IDX_ONE)
            begin
              p_d.tb1 = 1'b1;
              p_d.ii = rb[6:5];
              p_d.pi1 = rb[4:0];
              if (rb[6])
                p_d.err[`ARP_ERR_II] = 1'b1;
            end
            else if (p_q.idx == `ARP_IDX_TWO)
            begin
              p_d.tb2 = 1'b1;
              p_d.pi2 = rb;
            end
          end
          else if (p_q.pend[2])
          begin
            p_d.pend[2] = 1'b0;
            if (p_q.idx == `ARP_IDX_ONE)
              p_d.n = rb;
          end
          else
          begin
            p_d.pend = rb[7:4];
            p_d.tprev = rb[3:0];
            if (p_q.idx == `ARP_IDX_ONE)
              p_d.first_t = rb[3:0];
            if (rb[3:0] != `ARP_T0)
              p_d.tck_need = 1'b1;
            if (rb[3:0] == `ARP_T15)
              p_d.t15 = 1'b1;
            if (p_q.idx != `ARP_IDX_MAX)
              p_d.idx = p_q.idx + 4'h1;
          end
          if (p_d.pend == 4'h0)
            p_d.st = arp_after(p_q.k, p_d.tck_need);
        end
        ST_HIST:
        begin
          p_d.xsum = p_q.xsum ^ rb;
          p_d.hcnt = p_q.hcnt + 4'h1;
          if (p_d.hcnt == p_q.k)
            p_d.st = p_q.tck_need ? ST_TCK : ST_DONE;
        end
        ST_TCK:
        begin
          p_d.xsum = p_q.xsum ^ rb;
          if ((p_q.xsum ^ rb) != 8'h00)
            p_d.err[`ARP_ERR_TCK] = 1'b1;
          p_d.st = ST_DONE;
        end
        default:
          p_d.st = p_q.st;
      endcase
    end
    if (pps_done_i && p_q.st == ST_DONE && !p_q.ta2)
    begin
      p_d.pps_ok = 1'b1;
      p_d.pps_fidi = pps_fidi_i;
    end
  end

  // ******************************************************
  // Selected factors and parameters
  // ******************************************************
  logic [3:0] f_code, d_code;
  logic [11:0] f_val;
  logic [5:0] d_val;

  always_comb
  begin
    f_code = `ARP_CODE_DFLT;
    d_code = `ARP_CODE_DFLT;
    if (p_q.st == ST_DONE)
    begin
      if (p_q.ta2)
      begin
        if (p_q.ta2v[4])
        begin
          f_code = b_q.ctrl[3:0];
          d_code = b_q.ctrl[7:4];
        end
        else
        begin
          f_code = p_q.fi;
          d_code = p_q.di;
        end
      end
      else if (p_q.pps_ok)
      begin
        f_code = p_q.pps_fidi[7:4];
        d_code = p_q.pps_fidi[3:0];
      end
    end
    f_val = arp_f(f_code);
    d_val = arp_d(d_code);
    if (f_val == 12'h000 || d_val == 6'h00)
    begin
      f_val = `ARP_FD;
      d_val = `ARP_DD;
    end
  end

  always_comb
  begin
    o_d = '0;
    o_d.atr_done = (p_q.st == ST_DONE);
    o_d.mode_specific = o_d.atr_done && p_q.ta2;
    o_d.pps_applied = o_d.atr_done && p_q.pps_ok;
    o_d.f = f_val;
    o_d.d = d_val;
    o_d.etu_cycles = f_val / {6'h00, d_val};
    o_d.guard_n = p_q.n;
    o_d.q_use_fi = p_q.t15;
    o_d.proto = p_q.ta2 ? p_q.ta2v[3:0] : p_q.first_t;
    o_d.min_gap_etu = `ARP_GAP_STD;
    if (p_q.n == `ARP_N_SAME && o_d.proto == `ARP_T1)
      o_d.min_gap_etu = `ARP_GAP_T1;
    if (p_q.tb2 && p_q.pi2 >= `ARP_PI2_MIN && p_q.pi2 <= `ARP_PI2_MAX)
    begin
      o_d.vpp_conn = 1'b1;
      o_d.vpp_dv = p_q.pi2;
    end
    else if (p_q.tb1)
    begin
      o_d.vpp_conn = (p_q.pi1 >= `ARP_PI1_MIN) &&
                     (p_q.pi1 <= `ARP_PI1_MAX);
      if (o_d.vpp_conn)
        o_d.vpp_dv = 8'({3'h0, p_q.pi1} * `ARP_DV_PER_V);
    end
    else if (!p_q.t15)
    begin
      o_d.vpp_conn = 1'b1;
      o_d.vpp_dv = `ARP_DV_DFLT;
    end
    if (p_q.tb1)
      o_d.ipp_ma = (p_q.ii == 2'b00) ? `ARP_MA_25 :
                   (p_q.ii == 2'b01) ? `ARP_MA_50 : 6'h00;
    else if (!p_q.t15)
      o_d.ipp_ma = `ARP_MA_50;
    o_d.clk_stop = p_q.xi;
    o_d.class_sup = p_q.ui;
    o_d.error = (p_q.err != 5'h00);
  end

  // ******************************************************
  // AXI4-Lite slave
  // ******************************************************
  logic wr_fire, rd_fire;

  assign wr_fire = b_q.aw_held && b_q.w_held && !b_q.bvalid;
  assign rd_fire = axi_req_i.arvalid && !b_q.rvalid;

  always_comb
  begin
    b_d = b_q;
    if (axi_req_i.awvalid && !b_q.aw_held)
    begin
      b_d.aw_held = 1'b1;
      b_d.awaddr = axi_req_i.awaddr;
    end
    if (axi_req_i.wvalid && !b_q.w_held)
    begin
      b_d.w_held = 1'b1;
      b_d.wdata = axi_req_i.wdata;
      b_d.wstrb = axi_req_i.wstrb;
    end
    if (b_q.bvalid && axi_req_i.bready)
      b_d.bvalid = 1'b0;
    if (wr_fire)
    begin
      b_d.aw_held = 1'b0;
      b_d.w_held = 1'b0;
      b_d.bvalid = 1'b1;
      b_d.bresp = `ARP_RESP_ERR;
      if (b_q.awaddr == `ARP_OFS_CTRL)
      begin
        b_d.bresp = `ARP_RESP_OK;
        if (b_q.wstrb[0])
          b_d.ctrl = b_q.wdata[7:0];
      end
      else if (b_q.awaddr == `ARP_OFS_STATUS ||
               b_q.awaddr == `ARP_OFS_PARAM0 ||
               b_q.awaddr == `ARP_OFS_PARAM1 ||
               b_q.awaddr == `ARP_OFS_FACTOR)
        b_d.bresp = `ARP_RESP_OK;
    end
    if (b_q.rvalid && axi_req_i.rready)
      b_d.rvalid = 1'b0;
    if (rd_fire)
    begin
      b_d.rvalid = 1'b1;
      b_d.rresp = `ARP_RESP_OK;
      case (axi_req_i.araddr)
        `ARP_OFS_CTRL:
          b_d.rdata = {24'h00_0000, b_q.ctrl};
        `ARP_OFS_STATUS:
          b_d.rdata = {16'h0000, p_q.k, 1'b0, p_q.st, p_q.err,
                       o_q.pps_applied, o_q.mode_specific, o_q.atr_done};
        `ARP_OFS_PARAM0:
          b_d.rdata = {p_q.fi, p_q.di, p_q.n, 9'h000, p_q.ii, p_q.pi1};
        `ARP_OFS_PARAM1:
          b_d.rdata = {p_q.pi2, p_q.xi, p_q.ui, p_q.ta2v, p_q.first_t,
                       p_q.t15, p_q.tck_need, p_q.ta2, p_q.tb2};
        `ARP_OFS_FACTOR:
          b_d.rdata = {o_q.etu_cycles, 2'h0, o_q.d, o_q.f};
        default:
        begin
          b_d.rdata = 32'h0000_0000;
          b_d.rresp = `ARP_RESP_ERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      p_q <= '0;
      b_q <= '0;
      b_q.ctrl <= `ARP_CTRL_RST;
      o_q <= '0;
    end
    else
    begin
      p_q <= p_d;
      b_q <= b_d;
      o_q <= o_d;
    end
  end

  assign out_o = o_q;
  assign axi_rsp_o.awready = !b_q.aw_held;
  assign axi_rsp_o.wready = !b_q.w_held;
  assign axi_rsp_o.bvalid = b_q.bvalid;
  assign axi_rsp_o.bresp = b_q.bresp;
  assign axi_rsp_o.arready = !b_q.rvalid;
  assign axi_rsp_o.rvalid = b_q.rvalid;
  assign axi_rsp_o.rdata = b_q.rdata;
  assign axi_rsp_o.rresp = b_q.rresp;
endmodule
`default_nettype wire

// *** src/arp_params.svh ***
// Constants for the answer-to-reset parameter decoder
`ifndef ARP_PARAMS_SVH
`define ARP_PARAMS_SVH
`define ARP_AXI_AW 8
`define ARP_OFS_CTRL 8'h00
`define ARP_OFS_STATUS 8'h04
`define ARP_OFS_PARAM0 8'h08
`define ARP_OFS_PARAM1 8'h0C
`define ARP_OFS_FACTOR 8'h10
`define ARP_CTRL_RST 8'h11
`define ARP_RESP_OK 2'b00
`define ARP_RESP_ERR 2'b10
`define ARP_FD 12'h174
`define ARP_DD 6'h01
`define ARP_CODE_DFLT 4'h1
`define ARP_T0 4'h0
`define ARP_T1 4'h1
`define ARP_T15 4'hF
`define ARP_IDX_ONE 4'h1
`define ARP_IDX_TWO 4'h2
`define ARP_IDX_MAX 4'hF
`define ARP_N_SAME 8'hFF
`define ARP_GAP_STD 4'hC
`define ARP_GAP_T1 4'hB
`define ARP_PI1_MIN 5'h05
`define ARP_PI1_MAX 5'h19
`define ARP_PI2_MIN 8'h32
`define ARP_PI2_MAX 8'hFA
`define ARP_DV_DFLT 8'h32
`define ARP_DV_PER_V 8'h0A
`define ARP_MA_25 6'h19
`define ARP_MA_50 6'h32
`define ARP_UI_A 6'h01
`define ARP_UI_AB 6'h03
`define ARP_ERR_FI 0
`define ARP_ERR_DI 1
`define ARP_ERR_II 2
`define ARP_ERR_UI 3
`define ARP_ERR_TCK 4
`endif

// *** src/arp_pkg.sv ***
// Types for the answer-to-reset parameter decoder
package arp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_FMT, ST_IF, ST_HIST, ST_TCK, ST_DONE
  } arp_state_e;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } arp_axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } arp_axil_rsp_s;

  typedef struct packed {
    logic atr_done;
    logic mode_specific;
    logic pps_applied;
    logic [11:0] f;
    logic [5:0] d;
    logic [11:0] etu_cycles;
    logic [7:0] guard_n;
    logic q_use_fi;
    logic [3:0] min_gap_etu;
    logic vpp_conn;
    logic [7:0] vpp_dv;
    logic [5:0] ipp_ma;
    logic [1:0] clk_stop;
    logic [5:0] class_sup;
    logic [3:0] proto;
    logic error;
  } arp_out_s;

  typedef struct packed {
    arp_state_e st;
    logic [3:0] k;
    logic [3:0] hcnt;
    logic [3:0] pend;
    logic [3:0] idx;
    logic [3:0] tprev;
    logic t15;
    logic tck_need;
    logic xu_done;
    logic [7:0] xsum;
    logic [3:0] fi;
    logic [3:0] di;
    logic ta1;
    logic tb1;
    logic ta2;
    logic tb2;
    logic [1:0] ii;
    logic [4:0] pi1;
    logic [7:0] n;
    logic [7:0] ta2v;
    logic [7:0] pi2;
    logic [1:0] xi;
    logic [5:0] ui;
    logic [3:0] first_t;
    logic [4:0] err;
    logic pps_ok;
    logic [7:0] pps_fidi;
  } arp_parse_s;

  typedef struct packed {
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] ctrl;
  } arp_bus_s;
endpackage

// *** testbench/arp_card_model.sv ***
// Card byte source and reader event source for the decoder
`timescale 1ns/10ps
`default_nettype none
module arp_card_model (
  input wire logic clk_i,
  output logic atr_start_o,
  output logic warm_reset_o,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o,
  output logic pps_done_o,
  output logic [7:0] pps_fidi_o
);
  initial
  begin
    atr_start_o = 1'b0;
    warm_reset_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_byte_o = 8'h00;
    pps_done_o = 1'b0;
    pps_fidi_o = 8'h00;
  end
  // Released byte shows the inverse of the last one
  task automatic send(input logic [7:0] b);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_byte_o <= b;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_byte_o <= ~b;
  endtask
  task automatic atr(input logic [7:0] q[$], input logic tck,
                     input logic [7:0] bad);
    logic [7:0] x;
    x = 8'h00;
    @(posedge clk_i);
    atr_start_o <= 1'b1;
    @(posedge clk_i);
    atr_start_o <= 1'b0;
    foreach (q[i])
    begin
      x = x ^ q[i];
      send(q[i]);
    end
    if (tck)
      send(x ^ bad);
    repeat (3) @(posedge clk_i);
  endtask
  task automatic pps(input logic [7:0] fd);
    @(posedge clk_i);
    pps_done_o <= 1'b1;
    pps_fidi_o <= fd;
    @(posedge clk_i);
    pps_done_o <= 1'b0;
    pps_fidi_o <= ~fd;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic warm;
    @(posedge clk_i);
    warm_reset_o <= 1'b1;
    @(posedge clk_i);
    warm_reset_o <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// *** testbench/arp_decoder_bench.sv ***
// Self-checking bench for the answer-to-reset decoder
`timescale 1ns/10ps
`default_nettype none
module arp_decoder_bench;
  import arp_pkg::*;
  localparam logic [15:0] FT [12] = '{16'h0174, 16'h1174, 16'h222E,
    16'h32E8, 16'h445C, 16'h55D0, 16'h6744, 16'h9200, 16'hA300,
    16'hB400, 16'hC600, 16'hD800};
  localparam logic [11:0] DT [8] = '{12'h101, 12'h202, 12'h304,
    12'h408, 12'h510, 12'h620, 12'h80C, 12'h914};
  logic clk_i = 1'b0;
  logic resetn_i;
  arp_axil_req_s req;
  arp_axil_rsp_s rsp;
  arp_out_s o;
  wire logic ast, wrs, rxv, ppd;
  wire logic [7:0] rxb, ppf;
  logic [31:0] rd;
  logic [1:0] rr;
  int err_count;
  int samples_checked;
  arp_card_model m (.clk_i(clk_i), .atr_start_o(ast), .warm_reset_o(wrs),
    .rx_valid_o(rxv), .rx_byte_o(rxb), .pps_done_o(ppd), .pps_fidi_o(ppf));
  arp_decoder dut (.clk_i(clk_i), .resetn_i(resetn_i), .axi_req_i(req),
    .axi_rsp_o(rsp), .atr_start_i(ast), .warm_reset_i(wrs),
    .rx_valid_i(rxv), .rx_byte_i(rxb), .pps_done_i(ppd),
    .pps_fidi_i(ppf), .out_o(o));
  always #20 clk_i = ~clk_i;
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk_i);
      if (rsp.awready)
        req.awvalid <= 1'b0;
      if (rsp.wready)
        req.wvalid <= 1'b0;
      if (rsp.bvalid)
        break;
    end
    rr = rsp.bresp;
    req.bready <= 1'b0;
    if (n == 20)
    begin
      err_count++;
      wrap_up();
    end
  endtask
  task automatic axr(input logic [7:0] a);
    int n;
    @(posedge clk_i);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk_i);
      if (rsp.arready)
        req.arvalid <= 1'b0;
      if (rsp.rvalid)
        break;
    end
    rd = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'b0;
    if (n == 20)
    begin
      err_count++;
      wrap_up();
    end
  endtask
  task automatic t_plain;
    m.atr('{8'h00}, 1'b0, 8'h00);
    chk(o.atr_done, 1'b1);
    chk(o.etu_cycles, 12'h174);
    chk(o.guard_n, 8'h00);
    chk({o.vpp_dv, 2'b00, o.ipp_ma}, 16'h3232);
    chk({o.class_sup, o.clk_stop}, 8'h04);
    chk({o.mode_specific, o.proto, o.error}, 6'h00);
    $display("test plain done");
  endtask
  task automatic t_hist;
    m.atr('{8'h13, 8'h94, 8'h41, 8'h42}, 1'b0, 8'h00);
    chk(o.atr_done, 1'b0);
    m.send(8'h43);
    repeat (3) @(posedge clk_i);
    chk(o.atr_done, 1'b1);
    chk(o.f, 12'h174);
    axr(8'h08);
    chk(rd[31:24], 8'h94);
    axr(8'h04);
    chk(rd[15:12], 4'h3);
    m.pps(8'h94);
    chk({o.pps_applied, o.f, o.d}, 19'h4_8008);
    chk(o.etu_cycles, 12'h040);
    for (int i = 0; i < 12; i++)
    begin
      m.pps({FT[i][15:12], 4'h1});
      chk(o.f, FT[i][11:0]);
    end
    for (int i = 0; i < 8; i++)
    begin
      m.pps({4'h1, DT[i][11:8]});
      chk(o.d, DT[i][7:0]);
    end
    $display("test history and negotiation done");
  endtask
  task automatic t_spec;
    m.atr('{8'hF0, 8'h13, 8'h0A, 8'hFF, 8'h11, 8'h01}, 1'b1, 8'h00);
    chk({o.mode_specific, o.d, o.proto}, 11'h441);
    chk(o.etu_cycles, 12'h05D);
    chk({o.ipp_ma, o.vpp_dv}, 14'h1964);
    chk({o.guard_n, o.min_gap_etu, o.error}, 13'h1FF6);
    m.warm();
    chk({o.mode_specific, o.pps_applied}, 2'b00);
    axw(8'h00, 32'h0000_0024);
    chk(rr, 2'b00);
    m.atr('{8'hF0, 8'h13, 8'h0A, 8'hFF, 8'h11, 8'h11}, 1'b1, 8'h00);
    chk({o.f, o.d}, 18'h1_1702);
    $display("test specific mode done");
  endtask
  task automatic t_t15;
    for (int i = 0; i < 4; i++)
    begin
      m.atr('{8'h80, 8'h81, 8'h1F, {i[1:0], 6'h03}}, 1'b1, 8'h00);
      chk(o.clk_stop, i[1:0]);
      chk({o.class_sup, o.vpp_conn, o.q_use_fi}, 8'h0D);
    end
    $display("test global bytes done");
  endtask
  task automatic t_err;
    m.atr('{8'h10, 8'h70}, 1'b0, 8'h00);
    chk(o.error, 1'b1);
    m.atr('{8'h20, 8'h40}, 1'b0, 8'h00);
    chk({o.error, o.ipp_ma}, 7'h40);
    m.atr('{8'h80, 8'h01}, 1'b1, 8'h01);
    axr(8'h04);
    chk(rd[7], 1'b1);
    axr(8'h40);
    chk(rr, 2'b10);
    axw(8'h40, 32'h0000_0001);
    chk(rr, 2'b10);
    $display("test errors done");
  endtask
  initial
  begin
    resetn_i = 1'b0;
    req = '0;
    err_count = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    axr(8'h00);
    chk(rd, 32'h0000_0011);
    t_plain();
    t_hist();
    t_spec();
    t_t15();
    t_err();
    wrap_up();
  end
endmodule
`default_nettype wire

// *** testbench/arp_decoder_sva.sv ***
// Assertions for the answer-to-reset decoder ports
`timescale 1ns/10ps
`default_nettype none
module arp_decoder_sva
  import arp_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire arp_pkg::arp_axil_req_s axi_req_i,
  input wire arp_pkg::arp_axil_rsp_s axi_rsp_o,
  input wire logic atr_start_i,
  input wire logic warm_reset_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic pps_done_i,
  input wire logic [7:0] pps_fidi_i,
  input wire arp_pkg::arp_out_s out_o
);
  arp_out_s o;
  assign o = out_o;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  etu_ratio_a: assert property (
    o.d != '0 |-> o.etu_cycles == o.f / o.d)
    else $error("etu differs from f over d");
  ans_dflt_a: assert property (
    !o.atr_done && o.d != '0 |-> o.f == 12'h174 && o.d == 6'h01)
    else $error("factors not default during answer");
  nego_keep_a: assert property (
    o.atr_done && !o.mode_specific && !o.pps_applied
    |-> o.f == 12'h174 && o.d == 6'h01)
    else $error("negotiable mode left defaults early");
  pps_apply_a: assert property (
    pps_done_i && o.atr_done && !o.mode_specific && !warm_reset_i
    && !atr_start_i |-> ##[1:3] o.pps_applied)
    else $error("negotiated factors not applied");
  gap_rule_a: assert property (
    o.atr_done |-> o.min_gap_etu ==
    ((o.guard_n == 8'hFF && o.proto == 4'h1) ? 4'hB : 4'hC))
    else $error("minimum gap wrong");
  f_table_a: assert property (
    o.atr_done |-> o.f inside {12'h174, 12'h22E, 12'h2E8, 12'h45C,
    12'h5D0, 12'h744, 12'h200, 12'h300, 12'h400, 12'h600, 12'h800})
    else $error("clock factor outside table");
  vpp_range_a: assert property (
    o.atr_done && o.vpp_conn |-> o.vpp_dv inside {[8'h32:8'hFA]})
    else $error("programming voltage out of range");
  done_byte_a: assert property (
    $rose(o.atr_done) |-> $past(rx_valid_i, 2))
    else $error("answer completed without a byte");
  cover property (o.mode_specific);
  cover property (o.pps_applied);
  cover property (o.min_gap_etu == 4'hB);
endmodule
bind arp_decoder arp_decoder_sva u_sva (.*);
`default_nettype wire
